/* common/cacm_map.svh */
`ifndef CACM_MAP_SVH
`define CACM_MAP_SVH
// Compare value low bytes, modules 0 to 5
`define CACM_CPL0 8'hfb
`define CACM_CPL1 8'he9
`define CACM_CPL2 8'heb
`define CACM_CPL3 8'hed
`define CACM_CPL4 8'hfd
`define CACM_CPL5 8'hd2
// Compare value high bytes, modules 0 to 5
`define CACM_CPH0 8'hfc
`define CACM_CPH1 8'hea
`define CACM_CPH2 8'hec
`define CACM_CPH3 8'hee
`define CACM_CPH4 8'hfe
`define CACM_CPH5 8'hd3
// Mode control registers, modules 0 to 5
`define CACM_CPM0 8'hda
`define CACM_CPM1 8'hdb
`define CACM_CPM2 8'hdc
`define CACM_CPM3 8'hdd
`define CACM_CPM4 8'hde
`define CACM_CPM5 8'hce
// Counter mode register holding the six capture/compare flags
`define CACM_FLAGS 8'hd8
// Reset values
`define CACM_RST_BYTE 8'h00
`define CACM_RST_FLAGS 6'h00
`define CACM_RST_PINS 6'h00
`endif

/* common/cacm_pkg.sv */
package cacm_pkg;
  // Per-module mode control byte, bit 7 down to bit 0
  typedef struct packed {
    logic wide_pwm_select;
    logic comparator_function_enable;
    logic capture_pos_enable;
    logic capture_neg_enable;
    logic match_flag_enable;
    logic toggle_enable;
    logic pwm_mode_enable;
    logic flag_interrupt_enable;
  } cacm_mode_t;

  // Effective function of a module's output logic
  typedef enum logic [2:0] {
    CACM_FN_IDLE = 3'b000,
    CACM_FN_CMP = 3'b001,
    CACM_FN_PWM8 = 3'b010,
    CACM_FN_PWM16 = 3'b011,
    CACM_FN_FREQ = 3'b100
  } cacm_fn_t;

  // Kind of register an address selects
  typedef enum logic [1:0] {
    CACM_K_LOW = 2'b00,
    CACM_K_HIGH = 2'b01,
    CACM_K_MODE = 2'b10,
    CACM_K_FLAGS = 2'b11
  } cacm_kind_t;

  // Decoded register address
  typedef struct packed {
    logic hit;
    cacm_kind_t kind;
    logic [2:0] idx;
  } cacm_sel_t;
endpackage : cacm_pkg

/* design/cacm_top.sv */
// Summary of operation
// [RQ1] With match enable set, a counter match sets the module's flag.
// [RQ2] With toggle enable set, each counter match inverts the module's output pin.
// [RQ3] Toggle and PWM enables both set select frequency output mode.
// [RQ4] PWM enable alone drives a pulse-width-modulated waveform on the output pin.
// [RQ5] Wide PWM select clear gives 8-bit PWM, set gives 16-bit PWM.
// [RQ6] Each module has a read-write low byte of its compare value.
// [RQ7] Each module has a read-write high byte; both bytes reset to zero.
// [RQ8] Comparison, match, toggle and PWM act only while comparator enable is set.
// [RQ9] Flag interrupt enable lets a set flag raise the interrupt request.
`include "cacm_map.svh"

module cacm_top (
  input wire logic clk_sys_i,           // System clock
  input wire logic rst_n_i,             // Asynchronous reset, active low
  input wire logic [15:0] count_i,      // Shared counter value
  input wire logic count_step_i,        // Counter took a new value this cycle
  input wire logic [7:0] sfr_addr_i,    // Register address
  input wire logic sfr_wr_i,            // Register write strobe
  input wire logic [7:0] sfr_wdata_i,   // Register write data
  input wire logic sfr_rd_i,            // Register read strobe
  output logic [7:0] sfr_rdata_o,       // Read data, one cycle after strobe
  output logic [5:0] module_output_pin_o, // Module output pins
  output logic irq_o                    // Interrupt request, active high
);
  localparam int NMOD = 6;

  // Address decode shared by writes and reads
  function automatic cacm_pkg::cacm_sel_t sel_decode(input logic [7:0] a);
    cacm_pkg::cacm_sel_t s;
    s = '{hit: 1'b1, kind: cacm_pkg::CACM_K_LOW, idx: 3'h0};
    case (a)
      `CACM_CPL0: s.idx = 3'h0;
      `CACM_CPL1: s.idx = 3'h1;
      `CACM_CPL2: s.idx = 3'h2;
      `CACM_CPL3: s.idx = 3'h3;
      `CACM_CPL4: s.idx = 3'h4;
      `CACM_CPL5: s.idx = 3'h5;
      `CACM_CPH0: s = '{1'b1, cacm_pkg::CACM_K_HIGH, 3'h0};
      `CACM_CPH1: s = '{1'b1, cacm_pkg::CACM_K_HIGH, 3'h1};
      `CACM_CPH2: s = '{1'b1, cacm_pkg::CACM_K_HIGH, 3'h2};
      `CACM_CPH3: s = '{1'b1, cacm_pkg::CACM_K_HIGH, 3'h3};
      `CACM_CPH4: s = '{1'b1, cacm_pkg::CACM_K_HIGH, 3'h4};
      `CACM_CPH5: s = '{1'b1, cacm_pkg::CACM_K_HIGH, 3'h5};
      `CACM_CPM0: s = '{1'b1, cacm_pkg::CACM_K_MODE, 3'h0};
      `CACM_CPM1: s = '{1'b1, cacm_pkg::CACM_K_MODE, 3'h1};
      `CACM_CPM2: s = '{1'b1, cacm_pkg::CACM_K_MODE, 3'h2};
      `CACM_CPM3: s = '{1'b1, cacm_pkg::CACM_K_MODE, 3'h3};
      `CACM_CPM4: s = '{1'b1, cacm_pkg::CACM_K_MODE, 3'h4};
      `CACM_CPM5: s = '{1'b1, cacm_pkg::CACM_K_MODE, 3'h5};
      `CACM_FLAGS: s = '{1'b1, cacm_pkg::CACM_K_FLAGS, 3'h0};
      default: s.hit = 1'b0;
    endcase
    return s;
  endfunction : sel_decode

  // Effective output function from a mode byte
  function automatic cacm_pkg::cacm_fn_t fn_decode(input cacm_pkg::cacm_mode_t m);
    cacm_pkg::cacm_fn_t f;
    f = cacm_pkg::CACM_FN_CMP;
    if (!m.comparator_function_enable) begin
      f = cacm_pkg::CACM_FN_IDLE;
    end else if (m.toggle_enable && m.pwm_mode_enable) begin
      f = cacm_pkg::CACM_FN_FREQ;
    end else if (m.pwm_mode_enable) begin
      f = m.wide_pwm_select ? cacm_pkg::CACM_FN_PWM16 : cacm_pkg::CACM_FN_PWM8;
    end
    return f;
  endfunction : fn_decode

  logic [7:0] cpl_r [NMOD];
  logic [7:0] cpl_nxt [NMOD];
  logic [7:0] cph_r [NMOD];
  logic [7:0] cph_nxt [NMOD];
  cacm_pkg::cacm_mode_t mode_r [NMOD];
  cacm_pkg::cacm_mode_t mode_nxt [NMOD];
  logic [NMOD-1:0] flag_r;
  logic [NMOD-1:0] flag_nxt;
  logic [NMOD-1:0] pin_r;
  logic [NMOD-1:0] pin_nxt;
  logic [NMOD-1:0] ien_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic irq_r;
  logic irq_nxt;
  cacm_pkg::cacm_sel_t sel;
  cacm_pkg::cacm_fn_t fn [NMOD];
  logic [NMOD-1:0] match16;
  logic [NMOD-1:0] match8;

  assign sel = sel_decode(sfr_addr_i);

  // Per-module comparators, live only on a counter step
  genvar g;
  generate
    for (g = 0; g < NMOD; g++) begin : g_cmp
      assign fn[g] = fn_decode(mode_r[g]);
      assign match16[g] = mode_r[g].comparator_function_enable && count_step_i &&
                          (count_i == {cph_r[g], cpl_r[g]}); // RQ8
      assign match8[g] = mode_r[g].comparator_function_enable && count_step_i &&
                         (count_i[7:0] == cpl_r[g]); // RQ8
    end
  endgenerate

  // Next state of compare values, modes, flags and pins
  always_comb begin
    cpl_nxt = cpl_r;
    cph_nxt = cph_r;
    mode_nxt = mode_r;
    pin_nxt = pin_r;
    flag_nxt = flag_r;
    // Writing zero clears a flag, writing one leaves it
    if (sfr_wr_i && sel.hit && sel.kind == cacm_pkg::CACM_K_FLAGS) begin
      flag_nxt = flag_r & sfr_wdata_i[NMOD-1:0];
    end
    for (int i = 0; i < NMOD; i++) begin
      case (fn[i])
        cacm_pkg::CACM_FN_CMP: begin
          if (match16[i] && mode_r[i].toggle_enable) begin
            pin_nxt[i] = ~pin_r[i]; // RQ2
          end
        end
        cacm_pkg::CACM_FN_PWM8: begin
          pin_nxt[i] = (count_i[7:0] >= cpl_r[i]); // RQ4 RQ5
        end
        cacm_pkg::CACM_FN_PWM16: begin
          pin_nxt[i] = (count_i >= {cph_r[i], cpl_r[i]}); // RQ4 RQ5
        end
        cacm_pkg::CACM_FN_FREQ: begin
          if (match8[i]) begin
            pin_nxt[i] = ~pin_r[i]; // RQ3
            cpl_nxt[i] = 8'(cpl_r[i] + cph_r[i]); // RQ3
          end
        end
        default: begin
          pin_nxt[i] = pin_r[i]; // RQ8
        end
      endcase
      // Hardware set wins over a clear in the same cycle
      if (match16[i] && mode_r[i].match_flag_enable) begin
        flag_nxt[i] = 1'b1; // RQ1
      end
    end
    // Software writes to value and mode bytes
    if (sfr_wr_i && sel.hit && sel.idx < 3'(NMOD)) begin
      case (sel.kind)
        cacm_pkg::CACM_K_LOW: cpl_nxt[sel.idx] = sfr_wdata_i; // RQ6
        cacm_pkg::CACM_K_HIGH: cph_nxt[sel.idx] = sfr_wdata_i; // RQ7
        cacm_pkg::CACM_K_MODE: mode_nxt[sel.idx] = cacm_pkg::cacm_mode_t'(sfr_wdata_i);
        default: ;
      endcase
    end
  end

  // Registers, all clear at reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NMOD; i++) begin
        cpl_r[i] <= `CACM_RST_BYTE; // RQ6
        cph_r[i] <= `CACM_RST_BYTE; // RQ7
        mode_r[i] <= cacm_pkg::cacm_mode_t'(`CACM_RST_BYTE);
      end
      flag_r <= `CACM_RST_FLAGS;
      pin_r <= `CACM_RST_PINS;
    end else begin
      cpl_r <= cpl_nxt;
      cph_r <= cph_nxt;
      mode_r <= mode_nxt;
      flag_r <= flag_nxt;
      pin_r <= pin_nxt;
    end
  end

  // Read data and interrupt request
  always_comb begin
    rdata_nxt = `CACM_RST_BYTE;
    for (int i = 0; i < NMOD; i++) begin
      ien_nxt[i] = mode_nxt[i].flag_interrupt_enable;
    end
    irq_nxt = |(flag_nxt & ien_nxt); // RQ9
    if (sfr_rd_i && sel.hit) begin
      case (sel.kind)
        cacm_pkg::CACM_K_LOW: rdata_nxt = (sel.idx < 3'(NMOD)) ? cpl_r[sel.idx] : 8'h00;
        cacm_pkg::CACM_K_HIGH: rdata_nxt = (sel.idx < 3'(NMOD)) ? cph_r[sel.idx] : 8'h00;
        cacm_pkg::CACM_K_MODE: rdata_nxt = (sel.idx < 3'(NMOD)) ? 8'(mode_r[sel.idx]) : 8'h00;
        default: rdata_nxt = {2'h0, flag_r};
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= `CACM_RST_BYTE;
      irq_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign sfr_rdata_o = rdata_r;
  assign module_output_pin_o = pin_r;
  assign irq_o = irq_r;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // Checks per module
  generate
    for (g = 0; g < NMOD; g++) begin : g_chk
      property p_match_sets_flag;
        match16[g] && mode_r[g].match_flag_enable |=> flag_r[g];
      endproperty
      a_match_sets_flag: assert property (p_match_sets_flag) else $error("flag not set on match"); // RQ1

      property p_no_flag_without_mat;
        !flag_r[g] && !mode_r[g].match_flag_enable |=> !flag_r[g];
      endproperty
      a_no_flag_without_mat: assert property (p_no_flag_without_mat) else $error("flag set while off"); // RQ1

      property p_toggle_on_match;
        fn[g] == cacm_pkg::CACM_FN_CMP && mode_r[g].toggle_enable && match16[g]
          |=> pin_r[g] != $past(pin_r[g]);
      endproperty
      a_toggle_on_match: assert property (p_toggle_on_match) else $error("pin did not toggle"); // RQ2

      property p_no_toggle;
        fn[g] == cacm_pkg::CACM_FN_CMP && !mode_r[g].toggle_enable |=> $stable(pin_r[g]);
      endproperty
      a_no_toggle: assert property (p_no_toggle) else $error("pin moved with toggle off"); // RQ2

      property p_freq_toggle;
        fn[g] == cacm_pkg::CACM_FN_FREQ && match8[g] |=> pin_r[g] != $past(pin_r[g]);
      endproperty
      a_freq_toggle: assert property (p_freq_toggle) else $error("frequency output missed"); // RQ3

      property p_pwm8;
        fn[g] == cacm_pkg::CACM_FN_PWM8 |=> pin_r[g] == ($past(count_i[7:0]) >= $past(cpl_r[g]));
      endproperty
      a_pwm8: assert property (p_pwm8) else $error("8-bit PWM level wrong"); // RQ4

      property p_pwm16;
        fn[g] == cacm_pkg::CACM_FN_PWM16
          |=> pin_r[g] == ($past(count_i) >= {$past(cph_r[g]), $past(cpl_r[g])});
      endproperty
      a_pwm16: assert property (p_pwm16) else $error("16-bit PWM level wrong"); // RQ5

      property p_idle_holds;
        !mode_r[g].comparator_function_enable ##0 !flag_r[g]
          |=> $stable(pin_r[g]) && !flag_r[g];
      endproperty
      a_idle_holds: assert property (p_idle_holds) else $error("disabled module acted"); // RQ8

      property p_flag_holds;
        flag_r[g] && !(sfr_wr_i && sel.hit && sel.kind == cacm_pkg::CACM_K_FLAGS) |=> flag_r[g];
      endproperty
      a_flag_holds: assert property (p_flag_holds) else $error("flag lost without a clear"); // RQ1

      property p_flag_clear;
        sfr_wr_i && sel.hit && sel.kind == cacm_pkg::CACM_K_FLAGS && !sfr_wdata_i[g] &&
          !(match16[g] && mode_r[g].match_flag_enable) |=> !flag_r[g];
      endproperty
      a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by write"); // RQ1

      property p_freq_hold;
        fn[g] == cacm_pkg::CACM_FN_FREQ && !match8[g] |=> $stable(pin_r[g]);
      endproperty
      a_freq_hold: assert property (p_freq_hold) else $error("frequency output moved between matches"); // RQ3

      property p_freq_advance;
        fn[g] == cacm_pkg::CACM_FN_FREQ && match8[g] &&
          !(sfr_wr_i && sel.hit && sel.kind == cacm_pkg::CACM_K_LOW && sel.idx == 3'(g))
          |=> cpl_r[g] == 8'($past(cpl_r[g]) + $past(cph_r[g]));
      endproperty
      a_freq_advance: assert property (p_freq_advance) else $error("low byte did not advance"); // RQ3

      property p_high_kept;
        !(sfr_wr_i && sel.hit && sel.kind == cacm_pkg::CACM_K_HIGH && sel.idx == 3'(g))
          |=> $stable(cph_r[g]);
      endproperty
      a_high_kept: assert property (p_high_kept) else $error("high byte changed without write"); // RQ7
    end
  endgenerate

  property p_irq;
    irq_o == |(flag_r & {mode_r[5].flag_interrupt_enable, mode_r[4].flag_interrupt_enable,
      mode_r[3].flag_interrupt_enable, mode_r[2].flag_interrupt_enable,
      mode_r[1].flag_interrupt_enable, mode_r[0].flag_interrupt_enable});
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request wrong"); // RQ9

  property p_rdata_idle;
    !sfr_rd_i |=> sfr_rdata_o == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data left standing"); // RQ6

  property p_low_readback;
    sfr_wr_i && sfr_addr_i == `CACM_CPL0 && fn[0] != cacm_pkg::CACM_FN_FREQ ##1
      sfr_rd_i && !sfr_wr_i && sfr_addr_i == `CACM_CPL0 |=> sfr_rdata_o == $past(sfr_wdata_i, 2);
  endproperty
  a_low_readback: assert property (p_low_readback) else $error("low byte readback wrong"); // RQ6

  property p_high_readback;
    sfr_wr_i && sfr_addr_i == `CACM_CPH3 ##1
      sfr_rd_i && !sfr_wr_i && sfr_addr_i == `CACM_CPH3 |=> sfr_rdata_o == $past(sfr_wdata_i, 2);
  endproperty
  a_high_readback: assert property (p_high_readback) else $error("high byte readback wrong"); // RQ7
endmodule : cacm_top

/* verification/cacm_pin_load.sv */
// Load on the six output pins; counts every level change that it sees
module cacm_pin_load (
  input wire logic clk_sys_i,      // System clock
  input wire logic rst_n_i,        // Asynchronous reset, active low
  input wire logic [5:0] pins_i,   // Module output pins
  output logic [7:0] edge_cnt_o    // Pin level changes seen so far
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] last_r;

  // Pins are levels, so one change per pin per cycle at most
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_r <= 6'h00;
      edge_cnt_o <= 8'h00;
    end else begin
      last_r <= pins_i;
      edge_cnt_o <= edge_cnt_o + 8'($countones(pins_i ^ last_r));
    end
  end
endmodule : cacm_pin_load

/* verification/test_cacm_top.sv */
`include "cacm_map.svh"
module test_cacm_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic stp = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [15:0] cnt = 16'h0000;
  logic [7:0] rdat;
  logic [7:0] ec;
  logic [5:0] pin;
  logic [5:0] ep = 6'h00;
  logic irq;
  int err_total = 0;
  int n_compared = 0;
  logic [7:0] lo_a[6] = '{`CACM_CPL0, `CACM_CPL1, `CACM_CPL2, `CACM_CPL3, `CACM_CPL4, `CACM_CPL5};
  logic [7:0] hi_a[6] = '{`CACM_CPH0, `CACM_CPH1, `CACM_CPH2, `CACM_CPH3, `CACM_CPH4, `CACM_CPH5};
  logic [7:0] md_a[6] = '{`CACM_CPM0, `CACM_CPM1, `CACM_CPM2, `CACM_CPM3, `CACM_CPM4, `CACM_CPM5};

  cacm_top dut (
    .clk_sys_i(clk),
    .rst_n_i(rst_n),
    .count_i(cnt),
    .count_step_i(stp),
    .sfr_addr_i(adr),
    .sfr_wr_i(wr),
    .sfr_wdata_i(wd),
    .sfr_rd_i(rd),
    .sfr_rdata_o(rdat),
    .module_output_pin_o(pin),
    .irq_o(irq)
  );

  cacm_pin_load load (
    .clk_sys_i(clk),
    .rst_n_i(rst_n),
    .pins_i(pin),
    .edge_cnt_o(ec)
  );

  // Clock, 8 ns period
  always #4 clk = ~clk;

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Register write, one strobe cycle then one idle cycle
  task wrr(input logic [7:0] a, input logic [7:0] d);
    adr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask : wrr

  // Register read; data stands in the cycle after the strobe
  task rdc(input logic [7:0] a, input logic [7:0] e);
    adr = a;
    rd = 1'b1;
    @(negedge clk);
    chk("rdata", {8'h00, rdat}, {8'h00, e});
    rd = 1'b0;
    @(negedge clk);
  endtask : rdc

  // Counter step, then pins against the expected levels
  task stepc(input logic [15:0] c);
    cnt = c;
    stp = 1'b1;
    @(negedge clk);
    stp = 1'b0;
    @(negedge clk);
    chk("pins", {10'h000, pin}, {10'h000, ep});
  endtask : stepc

  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  // Reset values of all value and mode bytes and the flags
  task t_reset;
    for (int i = 0; i < 6; i++) begin
      rdc(lo_a[i], 8'h00);
      rdc(hi_a[i], 8'h00);
      rdc(md_a[i], 8'h00);
    end
    rdc(`CACM_FLAGS, 8'h00);
    chk("irq", {15'h0000, irq}, 16'h0000);
  endtask : t_reset

  // Value bytes read back, unmapped place reads zero
  task t_regs;
    for (int i = 0; i < 6; i++) begin
      wrr(lo_a[i], 8'ha0 + 8'(i));
      wrr(hi_a[i], 8'h50 + 8'(i));
      wrr(md_a[i], 8'h30);
    end
    for (int i = 0; i < 6; i++) begin
      rdc(lo_a[i], 8'ha0 + 8'(i));
      rdc(hi_a[i], 8'h50 + 8'(i));
      rdc(md_a[i], 8'h30);
      wrr(md_a[i], 8'h00);
    end
    wrr(8'h80, 8'hff);
    rdc(8'h80, 8'h00);
  endtask : t_regs

  // Match flag, toggle, comparator enable and interrupt mask
  task t_match;
    wrr(`CACM_CPL0, 8'h34);
    wrr(`CACM_CPH0, 8'h12);
    wrr(`CACM_CPM0, 8'h4d);
    ep[0] = 1'b1;
    stepc(16'h1234);
    chk("irq", {15'h0000, irq}, 16'h0001);
    rdc(`CACM_FLAGS, 8'h01);
    stepc(16'h1233);
    ep[0] = 1'b0;
    stepc(16'h1234);
    wrr(`CACM_FLAGS, 8'h00);
    chk("irq", {15'h0000, irq}, 16'h0000);
    wrr(`CACM_CPM0, 8'h0d);
    stepc(16'h1234);
    rdc(`CACM_FLAGS, 8'h00);
    wrr(`CACM_CPM0, 8'h4c);
    ep[0] = 1'b1;
    stepc(16'h1234);
    rdc(`CACM_FLAGS, 8'h01);
    chk("irq", {15'h0000, irq}, 16'h0000);
    wrr(`CACM_FLAGS, 8'hff);
    rdc(`CACM_FLAGS, 8'h01);
    wrr(`CACM_FLAGS, 8'h00);
    wrr(`CACM_CPM0, 8'h45);
    ep[0] = 1'b0;
    stepc(16'h1234);
    rdc(`CACM_FLAGS, 8'h00);
  endtask : t_match

  // Eight and sixteen bit pulse width, then PWM switched off
  task t_pwm;
    wrr(`CACM_CPL1, 8'h80);
    wrr(`CACM_CPH1, 8'h01);
    wrr(`CACM_CPM1, 8'h42);
    ep[1] = 1'b1;
    stepc(16'h0081);
    ep[1] = 1'b0;
    stepc(16'h007f);
    wrr(`CACM_CPM1, 8'hc2);
    stepc(16'h00ff);
    ep[1] = 1'b1;
    stepc(16'h0180);
    wrr(`CACM_CPM1, 8'h40);
    stepc(16'h0000);
  endtask : t_pwm

  // Frequency output: low byte match toggles and advances by high byte
  task t_freq;
    wrr(`CACM_CPL2, 8'h10);
    wrr(`CACM_CPH2, 8'h20);
    wrr(`CACM_CPM2, 8'h46);
    ep[2] = 1'b1;
    stepc(16'h0010);
    rdc(`CACM_CPL2, 8'h30);
    stepc(16'h0010);
    ep[2] = 1'b0;
    stepc(16'h0130);
    rdc(`CACM_CPL2, 8'h50);
    chk("edges", {8'h00, ec}, 16'h0009);
  endtask : t_freq

  // Write then read in the very next cycle returns the new byte
  task t_b2b(input logic [7:0] a, input logic [7:0] d);
    adr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b1;
    @(negedge clk);
    chk("rdata", {8'h00, rdat}, {8'h00, d});
    rd = 1'b0;
    @(negedge clk);
  endtask : t_b2b

  // Reset in mid-run clears value bytes, flags and pins
  task t_rerst;
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    rdc(`CACM_CPL2, 8'h00);
    rdc(`CACM_CPH2, 8'h00);
    rdc(`CACM_FLAGS, 8'h00);
    chk("pins", {10'h000, pin}, 16'h0000);
    chk("irq", {15'h0000, irq}, 16'h0000);
  endtask : t_rerst

  // Main sequence after ten reset cycles
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_regs();
    t_match();
    t_pwm();
    t_freq();
    t_b2b(`CACM_CPL0, 8'h5a);
    t_b2b(`CACM_CPH3, 8'ha5);
    t_rerst();
    give_verdict();
  end

  // Limit on the whole run
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule : test_cacm_top
